// *** common/qct_consts.vh ***
`ifndef QCT_CONSTS_VH
`define QCT_CONSTS_VH

// Control word field positions.
`define QCT_CW_IRQ_EN 7
`define QCT_CW_COUNTER_MODE 6
`define QCT_CW_PRESC_256 5
`define QCT_CW_RISING_EDGE 4
`define QCT_CW_TRIG_START 3
`define QCT_CW_TC_FOLLOWS 2
`define QCT_CW_SOFT_RESET 1
`define QCT_CW_IS_CONTROL 0

// Reset values.
`define QCT_CTRL_RESET 8'h00
`define QCT_TC_RESET 8'h00
`define QCT_CNT_RESET 8'h00
`define QCT_VEC_RESET 5'h00

// Prescaler terminal values for divide by 16 and by 256.
`define QCT_PRESC_TOP_16 8'h0f
`define QCT_PRESC_TOP_256 8'hff

// Return-from-interrupt opcode pair seen on instruction fetches.
`define QCT_RETURN_FROM_IRQ_OPCODE_PREFIX 8'hed
`define QCT_RETURN_FROM_IRQ_OPCODE_OPCODE 8'h4d

// Vector field layout: high bits from software, channel code, zero bit.
`define QCT_VEC_HI_MSB 7
`define QCT_VEC_HI_LSB 3

`endif

// *** verilog/qct_top.v ***
// Function
// - Vector bit zero always zero.
// - Snoop fetches, return opcode ends service.
// - Eight-bit three-state data bus, D0 lowest.
// - Two select bits pick one channel.
// - Chip select enables writes and counter reads.
// - Write when request, select, read high.
// - Read drives selected down counter value.
// - Acknowledge drives vector when chain grants.
// - High chain input means upstream idle.
// - Chain output high only when idle.
// - Interrupt request on enabled zero count.
// - Reset stops channels, quiets all outputs.
// - Per-channel trigger input, selectable edge.
// - Channels zero to two pulse zero count.
// - Control bit six selects counter mode.
// - Decrement on next clock after edge.
// - Late edge defers decrement one clock.
// - Control bit four selects trigger edge.
// - Control bit seven enables zero interrupt.
// - Zero reloads time constant without gap.
// - New constant loads after current count.
// - Vector: five high bits, channel, zero.
// - Channel zero highest, preemption downward only.
// - Bit zero set marks control word.
// - Bit four set rising, clear falling.
`timescale 1ns/1ps
`default_nettype none
`include "qct_consts.vh"

module qct_top #(
    parameter NUM_CH = 4
) (
    // System.
    input wire clock,
    input wire rst,
    // Host data bus, split into input, output and enable.
    input wire [7:0] data_in,
    output reg [7:0] data_out,
    output reg data_oe_n,
    // Host bus strobes and channel select.
    input wire chan_sel_hi,
    input wire chan_sel_lo,
    input wire chip_select_n,
    input wire io_request_n,
    input wire read_n,
    input wire first_machine_cycle_n,
    // Interrupt daisy chain and open-drain request.
    input wire priority_chain_in,
    output wire priority_chain_out,
    output wire irq_out,
    output wire irq_oe_n,
    // Channel pins.
    input wire [3:0] ext_clock_trigger,
    output wire [2:0] zero_count_pulse
);

    // Bus cycle decode.
    wire [1:0] sel;
    wire wr_cond;
    wire rd_cond;
    wire ack_cond;
    wire fetch_cond;
    reg wr_prev;
    reg ack_prev;
    reg fetch_prev;
    wire wr_take;
    wire ack_take;

    // Per-channel results gathered into flat vectors.
    wire [8*NUM_CH-1:0] cnt_flat;
    wire [NUM_CH-1:0] zc_evt;
    wire [NUM_CH-1:0] ie_clear;
    wire [NUM_CH-1:0] expect_tc;
    wire [NUM_CH-1:0] ie_en;

    // Interrupt state.
    reg [4:0] vec_hi;
    reg [NUM_CH-1:0] pending;
    reg [NUM_CH-1:0] in_service;
    reg [NUM_CH-1:0] next_pending;
    reg [NUM_CH-1:0] next_in_service;
    reg [NUM_CH-1:0] eligible;
    reg [NUM_CH-1:0] blocked;
    reg [1:0] winner;
    reg [NUM_CH-1:0] winner_mask;
    reg [NUM_CH-1:0] return_from_irq_opcode_mask;
    reg ack_own;
    reg [7:0] fetch_byte;
    reg [7:0] last_opcode;
    wire return_from_irq_opcode_seen;
    integer k;

    assign sel = {chan_sel_hi, chan_sel_lo};

    assign wr_cond = ~chip_select_n & ~io_request_n & read_n & first_machine_cycle_n;
    assign rd_cond = ~chip_select_n & ~io_request_n & ~read_n & first_machine_cycle_n;
    assign ack_cond = ~first_machine_cycle_n & ~io_request_n;
    assign fetch_cond = ~first_machine_cycle_n & ~read_n & io_request_n;

    // A strobe spans several clocks, so each write and acknowledge cycle acts once on its first clock.
    assign wr_take = wr_cond & ~wr_prev;
    assign ack_take = ack_cond & ~ack_prev;

    always @(posedge clock or posedge rst) begin
        if (rst) begin
            wr_prev <= 1'b0;
            ack_prev <= 1'b0;
            fetch_prev <= 1'b0;
        end else begin
            wr_prev <= wr_cond;
            ack_prev <= ack_cond;
            fetch_prev <= fetch_cond;
        end
    end

    // One counter channel per generate entry.
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g = g + 1) begin : ch
            reg [7:0] ctrl;
            reg [7:0] tc;
            reg [7:0] cnt;
            reg [7:0] presc;
            reg tc_next;
            reg running;
            reg armed;
            reg trig_prev;
            reg zc;
            wire my_wr;
            wire edge_rise;
            wire edge_fall;
            wire active_edge;
            wire tick;

            assign my_wr = wr_take & (sel == g);
            assign edge_rise = ext_clock_trigger[g] & ~trig_prev;
            assign edge_fall = ~ext_clock_trigger[g] & trig_prev;
            assign active_edge = ctrl[`QCT_CW_RISING_EDGE] ? edge_rise : edge_fall;
            assign tick = running & (ctrl[`QCT_CW_COUNTER_MODE] ? active_edge :
                          (presc == 8'h00));
            assign zc_evt[g] = zc;
            assign cnt_flat[8*g +: 8] = cnt;
            assign ie_clear[g] = my_wr & ~tc_next & data_in[`QCT_CW_IS_CONTROL] &
                                 ~data_in[`QCT_CW_IRQ_EN];
            assign expect_tc[g] = tc_next;
            assign ie_en[g] = ctrl[`QCT_CW_IRQ_EN];

            // Channel state. Inputs arrive synchronous, so an edge is seen on the clock
            // after it happens and a late edge simply falls to the clock after that.
            always @(posedge clock or posedge rst) begin
                if (rst) begin
                    ctrl <= `QCT_CTRL_RESET;
                    tc <= `QCT_TC_RESET;
                    cnt <= `QCT_CNT_RESET;
                    presc <= 8'h00;
                    tc_next <= 1'b0;
                    running <= 1'b0;
                    armed <= 1'b0;
                    trig_prev <= 1'b0;
                    zc <= 1'b0;
                end else begin
                    trig_prev <= ext_clock_trigger[g];
                    zc <= 1'b0;
                    // Timer prescaler, free running while the channel runs.
                    if (running & ~ctrl[`QCT_CW_COUNTER_MODE]) begin
                        if (presc == 8'h00) begin
                            presc <= ctrl[`QCT_CW_PRESC_256] ? `QCT_PRESC_TOP_256 :
                                     `QCT_PRESC_TOP_16;
                        end else begin
                            presc <= presc - 8'h01;
                        end
                    end
                    // A timer waiting for its trigger starts on the active edge.
                    if (armed & active_edge) begin
                        armed <= 1'b0;
                        running <= 1'b1;
                    end
                    if (tick) begin
                        if (cnt == 8'h01) begin
                            cnt <= tc;
                            zc <= 1'b1;
                        end else begin
                            cnt <= cnt - 8'h01;
                        end
                    end
                    if (my_wr) begin
                        if (tc_next) begin
                            tc <= data_in;
                            tc_next <= 1'b0;
                            // A running channel keeps counting; the constant waits for zero.
                            if (~running) begin
                                cnt <= data_in;
                                presc <= ctrl[`QCT_CW_PRESC_256] ? `QCT_PRESC_TOP_256 :
                                         `QCT_PRESC_TOP_16;
                                if (ctrl[`QCT_CW_COUNTER_MODE] |
                                    ~ctrl[`QCT_CW_TRIG_START]) begin
                                    running <= 1'b1;
                                end else begin
                                    armed <= 1'b1;
                                end
                            end
                        end else if (data_in[`QCT_CW_IS_CONTROL]) begin
                            // control word
                            // The soft reset bit is a pulse, never stored.
                            ctrl <= {data_in[7:2], 1'b0, data_in[0]};
                            tc_next <= data_in[`QCT_CW_TC_FOLLOWS];
                            if (data_in[`QCT_CW_SOFT_RESET]) begin
                                running <= 1'b0;
                                armed <= 1'b0;
                            end
                        end
                    end
                end
            end
        end
    endgenerate

    assign zero_count_pulse = zc_evt[2:0];

    // priority and preemption
    // A channel may interrupt only if neither it nor a higher channel is in service.
    always @* begin
        blocked = {NUM_CH{1'b0}};
        eligible = {NUM_CH{1'b0}};
        winner = 2'd0;
        winner_mask = {NUM_CH{1'b0}};
        return_from_irq_opcode_mask = {NUM_CH{1'b0}};
        for (k = 0; k < NUM_CH; k = k + 1) begin
            if (k == 0) begin
                blocked[k] = in_service[k];
            end else begin
                blocked[k] = blocked[k-1] | in_service[k];
            end
            eligible[k] = pending[k] & ~blocked[k];
        end
        for (k = NUM_CH - 1; k >= 0; k = k - 1) begin
            if (eligible[k]) begin
                winner = k[1:0];
                winner_mask = {NUM_CH{1'b0}};
                winner_mask[k] = 1'b1;
            end
            if (in_service[k]) begin
                return_from_irq_opcode_mask = {NUM_CH{1'b0}};
                return_from_irq_opcode_mask[k] = 1'b1;
            end
        end
    end

    assign return_from_irq_opcode_seen = fetch_prev & ~fetch_cond & (last_opcode == `QCT_RETURN_FROM_IRQ_OPCODE_PREFIX) &
                       (fetch_byte == `QCT_RETURN_FROM_IRQ_OPCODE_OPCODE);

    // Fetch snooping: the byte present at the end of a fetch is kept as the opcode.
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            fetch_byte <= 8'h00;
            last_opcode <= 8'h00;
        end else begin
            if (fetch_cond) begin
                fetch_byte <= data_in;
            end
            if (fetch_prev & ~fetch_cond) begin
                last_opcode <= fetch_byte;
            end
        end
    end

    // Pending and in-service updates; a new zero count wins over any clear.
    always @* begin
        next_pending = pending;
        next_in_service = in_service;
        if (ack_take & priority_chain_in) begin
            next_pending = next_pending & ~winner_mask;
            next_in_service = next_in_service | winner_mask;
        end
        next_pending = next_pending & ~ie_clear;
        next_pending = next_pending | (zc_evt & ie_en);
        if (return_from_irq_opcode_seen) begin
            next_in_service = next_in_service & ~return_from_irq_opcode_mask;
        end
    end

    // Interrupt registers and the vector's software-written high bits.
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            pending <= {NUM_CH{1'b0}};
            in_service <= {NUM_CH{1'b0}};
            vec_hi <= `QCT_VEC_RESET;
            ack_own <= 1'b0;
        end else begin
            pending <= next_pending;
            in_service <= next_in_service;
            // Vector words go to channel 0 with bit 0 clear.
            if (wr_take & (sel == 2'd0) & ~expect_tc[0] & ~data_in[`QCT_CW_IS_CONTROL]) begin
                vec_hi <= data_in[`QCT_VEC_HI_MSB:`QCT_VEC_HI_LSB];
            end
            if (ack_take) begin
                ack_own <= priority_chain_in & (|eligible);
            end else if (~ack_cond) begin
                ack_own <= 1'b0;
            end
        end
    end

    // registered data drivers
    // Data and enable are both registered, so the bus answers one clock into a cycle.
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            data_out <= 8'h00;
            data_oe_n <= 1'b1;
        end else begin
            if (ack_take) begin
                data_out <= {vec_hi, winner, 1'b0};
                data_oe_n <= ~(priority_chain_in & (|eligible));
            end else if (ack_cond) begin
                data_oe_n <= ~ack_own;
            end else if (rd_cond) begin
                data_out <= cnt_flat[8*sel +: 8];
                data_oe_n <= 1'b0;
            end else begin
                data_oe_n <= 1'b1;
            end
        end
    end

    assign priority_chain_out = priority_chain_in & ~(|in_service);
    assign irq_out = 1'b0;
    assign irq_oe_n = ~(|eligible);

endmodule // qct_top

`default_nettype wire

// *** sim/qct_chk.sv ***
`timescale 1ns/1ps
`default_nettype none

module qct_chk (
    // Clock and reset.
    input wire logic clock,
    input wire logic rst,
    // Host bus strobes and answer.
    input wire logic io_request_n,
    input wire logic read_n,
    input wire logic chip_select_n,
    input wire logic first_machine_cycle_n,
    input wire logic [7:0] data_out,
    input wire logic data_oe_n,
    // Chain, request and pulse pins.
    input wire logic priority_chain_in,
    input wire logic priority_chain_out,
    input wire logic irq_oe_n,
    input wire logic [2:0] zero_count_pulse
);
    // One clock domain, so clocking and disable are shared.
    default clocking qct_cb @(posedge clock);
    endclocking
    default disable iff (rst);

    reset_quiet_a: assert property (disable iff (1'b0) rst |-> data_oe_n && irq_oe_n
        && zero_count_pulse == 3'h0 && priority_chain_out == priority_chain_in)
        else $error("outputs active during reset");
    chain_gate_a: assert property (priority_chain_out |-> priority_chain_in)
        else $error("chain out high while chain in low");
    read_drive_a: assert property (!chip_select_n && !io_request_n && !read_n
        && first_machine_cycle_n |=> !data_oe_n)
        else $error("read not answered");
    bus_float_a: assert property (io_request_n |=> data_oe_n)
        else $error("bus driven without request");
    vec_even_a: assert property (!data_oe_n && $past(!first_machine_cycle_n)
        |-> !data_out[0])
        else $error("vector bit zero set");
    ack_blocked_a: assert property ($fell(io_request_n) && !first_machine_cycle_n
        && !priority_chain_in |=> data_oe_n)
        else $error("vector driven without priority");
    serve_block_a: assert property (!data_oe_n && !first_machine_cycle_n
        && $past(!first_machine_cycle_n) |-> !priority_chain_out)
        else $error("chain open while serving");
    pulse_single_a: assert property (|zero_count_pulse |=>
        (zero_count_pulse & $past(zero_count_pulse)) == 3'h0)
        else $error("zero pulse longer than one clock");
endmodule // qct_chk

bind qct_top qct_chk chk (.clock(clock), .rst(rst), .io_request_n(io_request_n),
    .read_n(read_n), .chip_select_n(chip_select_n),
    .first_machine_cycle_n(first_machine_cycle_n), .data_out(data_out),
    .data_oe_n(data_oe_n), .priority_chain_in(priority_chain_in),
    .priority_chain_out(priority_chain_out), .irq_oe_n(irq_oe_n),
    .zero_count_pulse(zero_count_pulse));

`default_nettype wire

// *** sim/qct_host.sv ***
`timescale 1ns/1ps
`default_nettype none

module qct_host (
    // Clock.
    input wire logic clock,
    // Device answer.
    input wire logic [7:0] data_out,
    input wire logic data_oe_n,
    // Bus pins toward the device.
    output logic [7:0] data_in,
    output logic chan_sel_hi,
    output logic chan_sel_lo,
    output logic chip_select_n,
    output logic io_request_n,
    output logic read_n,
    output logic first_machine_cycle_n
);
    logic [7:0] drv;

    assign data_in = data_oe_n ? drv : data_out;

    // Bus idle at time zero.
    initial begin
        drv = 8'h00;
        {chip_select_n, io_request_n, read_n, first_machine_cycle_n} = 4'hf;
        {chan_sel_hi, chan_sel_lo} = 2'h0;
    end

    // strobes {cs,io_request_n,rd,m1} held five clocks, answer kept
    task automatic bus(input logic [1:0] ch, input logic [3:0] k, input logic [7:0] d,
                       output logic [7:0] q, output logic ok);
        q = 8'h00;
        ok = 1'b0;
        @(posedge clock);
        {chip_select_n, io_request_n, read_n, first_machine_cycle_n} <= k;
        {chan_sel_hi, chan_sel_lo} <= ch;
        drv <= d;
        repeat (4) begin
            @(posedge clock);
            #1;
            if (data_oe_n === 1'b0 && !ok) begin
                q = data_out;
                ok = 1'b1;
            end
        end
        @(posedge clock);
        {chip_select_n, io_request_n, read_n, first_machine_cycle_n} <= 4'hf;
        // A released bus shows the inverse, so stale data cannot pass.
        drv <= ~d;
        @(posedge clock);
    endtask
endmodule // qct_host

`default_nettype wire

// *** sim/tb.sv ***
`timescale 1ns/1ps
`default_nettype none

module tb;
    typedef struct {logic [1:0] ch; logic [7:0] cw; logic [7:0] tc; int n;
                    logic [7:0] cnt; int p;} qct_row;
    logic clock = 1'b0;
    logic rst = 1'b0;
    logic priority_chain_in = 1'b1;
    logic [3:0] trig = 4'h0;
    logic [7:0] data_in, data_out, q;
    logic data_oe_n, chan_sel_hi, chan_sel_lo, chip_select_n, io_request_n, read_n;
    logic first_machine_cycle_n, priority_chain_out, irq_out, irq_oe_n, ok;
    logic [2:0] zero_count_pulse;
    int fail_count = 0;
    int checked = 0;
    int pc [3];
    // Channel, control word, constant, edges, then count and pulses expected.
    qct_row rows [4] = '{'{2'd0, 8'h55, 8'h05, 3, 8'h02, 0},
                         '{2'd1, 8'h45, 8'h03, 4, 8'h02, 1},
                         '{2'd2, 8'h55, 8'h00, 2, 8'hfe, 0},
                         '{2'd3, 8'h45, 8'h01, 2, 8'h01, 0}};

    qct_top uut (.clock(clock), .rst(rst), .data_in(data_in), .data_out(data_out),
        .data_oe_n(data_oe_n), .chan_sel_hi(chan_sel_hi), .chan_sel_lo(chan_sel_lo),
        .chip_select_n(chip_select_n), .io_request_n(io_request_n), .read_n(read_n),
        .first_machine_cycle_n(first_machine_cycle_n),
        .priority_chain_in(priority_chain_in), .priority_chain_out(priority_chain_out),
        .irq_out(irq_out), .irq_oe_n(irq_oe_n), .ext_clock_trigger(trig),
        .zero_count_pulse(zero_count_pulse));
    qct_host host (.clock(clock), .data_out(data_out), .data_oe_n(data_oe_n),
        .data_in(data_in), .chan_sel_hi(chan_sel_hi), .chan_sel_lo(chan_sel_lo),
        .chip_select_n(chip_select_n), .io_request_n(io_request_n), .read_n(read_n),
        .first_machine_cycle_n(first_machine_cycle_n));

    // Free-running system clock.
    always #5 clock = ~clock;

    // Tally zero-count pulses per channel.
    always @(posedge clock) begin
        for (int i = 0; i < 3; i++) begin
            if (zero_count_pulse[i] === 1'b1) pc[i]++;
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask

    // Each repetition gives one rising and one falling edge, so one active edge.
    task automatic pulse_trig(input logic [1:0] ch, input int n);
        repeat (n) begin
            @(posedge clock);
            trig[ch] <= 1'b1;
            repeat (3) @(posedge clock);
            trig[ch] <= 1'b0;
            repeat (3) @(posedge clock);
        end
    endtask

    task automatic wait_irq(input logic want);
        int i;
        #1;
        for (i = 0; i < 40 && irq_oe_n !== want; i++) @(posedge clock);
        chk({7'h0, irq_oe_n}, {7'h0, want}, "irq");
        if (i == 40) report_and_stop();
    endtask

    task automatic report_and_stop();
        $display("checks %0d errors %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        // A real rising edge of reset, so the asynchronous branch runs before the first clock.
        rst <= 1'b1;
        repeat (4) @(posedge clock);
        #1;
        chk({2'h0, data_oe_n, irq_oe_n, zero_count_pulse, priority_chain_out}, 8'h31, "rst");
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        foreach (rows[r]) begin
            pc = '{0, 0, 0};
            host.bus(rows[r].ch, 4'b0011, rows[r].cw, q, ok);
            host.bus(rows[r].ch, 4'b0011, rows[r].tc, q, ok);
            pulse_trig(rows[r].ch, rows[r].n);
            host.bus(rows[r].ch, 4'b0001, 8'h00, q, ok);
            chk(q, rows[r].cnt, "count");
            if (rows[r].ch != 2'd3) chk(8'(pc[rows[r].ch]), 8'(rows[r].p), "pulses");
        end
        host.bus(2'd2, 4'b0011, 8'h55, q, ok);
        host.bus(2'd2, 4'b0011, 8'h03, q, ok);
        host.bus(2'd2, 4'b0001, 8'h00, q, ok);
        chk(q, 8'hfe, "count kept");
        // vector word, then an enabled channel
        host.bus(2'd0, 4'b0011, 8'hb0, q, ok);
        host.bus(2'd1, 4'b0011, 8'hd5, q, ok);
        host.bus(2'd1, 4'b0011, 8'h01, q, ok);
        pulse_trig(2'd1, 2);
        wait_irq(1'b0);
        chk({7'h0, irq_out}, 8'h00, "irq level");
        priority_chain_in <= 1'b0;
        host.bus(2'd0, 4'b1010, 8'h00, q, ok);
        chk({7'h0, ok}, 8'h00, "ack refused");
        priority_chain_in <= 1'b1;
        host.bus(2'd0, 4'b1010, 8'h00, q, ok);
        chk(q, 8'hb2, "vector");
        chk(q & 8'h01, 8'h00, "table entry even");
        chk({7'h0, priority_chain_out}, 8'h00, "chain held");
        wait_irq(1'b1);
        // return opcode pair snooped on fetches
        host.bus(2'd0, 4'b1100, 8'hed, q, ok);
        host.bus(2'd0, 4'b1100, 8'h4d, q, ok);
        @(posedge clock);
        #1;
        chk({7'h0, priority_chain_out}, 8'h01, "chain freed");
        pulse_trig(2'd1, 1);
        wait_irq(1'b0);
        // Channel 0 joins channel 1 in pending; it must win and then block channel 1.
        host.bus(2'd0, 4'b0011, 8'hd5, q, ok);
        host.bus(2'd0, 4'b0011, 8'h01, q, ok);
        pulse_trig(2'd0, 2);
        host.bus(2'd0, 4'b1010, 8'h00, q, ok);
        chk(q, 8'hb0, "vector priority");
        wait_irq(1'b1);
        rst <= 1'b1;
        priority_chain_in <= 1'b0;
        @(posedge clock);
        #1;
        chk({2'h0, data_oe_n, irq_oe_n, zero_count_pulse, priority_chain_out}, 8'h30, "rst");
        report_and_stop();
    end
endmodule // tb

`default_nettype wire
